// File: dsau_unit.sv
// Data-space address unit: decode, byte lanes, misalignment trap, X/Y read paths
`timescale 1ns/100ps
module dsau_unit
  import dsau_pkg::*;
#(
  parameter logic [15:0] RAM_END = DSAU_RAM_END,
  parameter logic [15:0] XY_BOUNDARY = DSAU_XY_BOUNDARY
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire dsau_req_type x_rd_req_in,
  input wire dsau_req_type y_rd_req_in,
  input wire logic mac_class_in,
  input wire dsau_req_type wr_req_in,
  input wire logic [15:0] wr_data_in,
  input wire logic instr_done_in,
  input wire logic [15:0] x_mem_rdata_in,
  input wire logic [15:0] y_mem_rdata_in,
  input wire logic [15:0] sfr_rdata_in,
  input wire logic sfr_hit_in,
  input wire logic [15:0] psv_rdata_in,
  input wire logic [15:0] wreg_value_in,
  input wire logic [7:0] load_byte_in,
  input wire logic byte_load_in,
  input wire dsau_ext_type ext_op_in,
  output logic [15:0] x_rd_addr_out,
  output logic [15:0] y_rd_addr_out,
  output logic [15:0] psv_addr_out,
  output logic psv_rd_out,
  output logic [15:0] wr_addr_out,
  output logic [15:0] wr_data_out,
  output logic [1:0] wr_lane_out,
  output logic wr_sfr_out,
  output dsau_rsp_type x_rsp_out,
  output dsau_rsp_type y_rsp_out,
  output logic [15:0] x_ptr_next_out,
  output logic [15:0] y_ptr_next_out,
  output logic [15:0] w_ptr_next_out,
  output logic [15:0] wreg_result_out,
  output logic trap_out,
  output logic trap_is_write_out
);

  // Effective address from one generator request
  function automatic logic [15:0] calc_ea(input dsau_req_type r);
    logic [15:0] ea;
    ea = r.pointer;
    unique case (r.mode)
      DSAU_ADR_WREG: ea = r.pointer;
      DSAU_ADR_NEAR: ea = {{(DSAU_AW - DSAU_NEAR_BITS){1'b0}},
                           r.literal[DSAU_NEAR_BITS-1:0]};
      DSAU_ADR_DIRECT: ea = r.literal;
    endcase
    return ea;
  endfunction

  // Region decode of one byte address
  function automatic dsau_region_type region(input logic [15:0] ea);
    dsau_region_type g;
    if (ea[DSAU_TOP_BIT]) g = DSAU_REG_PSV;
    else if (ea <= DSAU_SFR_LAST) g = DSAU_REG_SFR;
    else if (ea < RAM_END) g = DSAU_REG_RAM;
    else g = DSAU_REG_NONE;
    return g;
  endfunction

  // Post-modified pointer, scaled by size
  function automatic logic [15:0] next_ptr(input dsau_req_type r);
    logic [15:0] p;
    p = r.pointer;
    if (r.post_inc && r.mode == DSAU_ADR_WREG)
      p = r.pointer + (r.is_byte ? DSAU_STEP_BYTE : DSAU_STEP_WORD);
    return p;
  endfunction

  // Byte select onto low lane, upper lane zero
  function automatic logic [15:0] lane_pick(input logic [15:0] w, input logic odd, input logic b);
    logic [15:0] v;
    v = w;
    if (b) v = {DSAU_BYTE_ZERO, odd ? w[15:8] : w[7:0]};
    return v;
  endfunction

  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic [15:0] w_ea;
  dsau_region_type x_reg_kind;
  dsau_region_type y_reg_kind;
  dsau_region_type x_kind_reg;
  dsau_region_type y_kind_reg;
  logic x_odd_reg;
  logic x_byte_reg;
  logic y_odd_reg;
  logic y_byte_reg;
  logic x_mis;
  logic w_mis;
  logic y_act;
  logic sfr_hit_s1_reg;
  logic sfr_hit_reg;
  logic pend_rd_reg;
  logic pend_wr_reg;

  // Independent generators for X read, Y read and write
  assign x_ea = calc_ea(x_rd_req_in);
  assign y_ea = calc_ea(y_rd_req_in);
  assign w_ea = calc_ea(wr_req_in);
  assign x_reg_kind = region(x_ea);
  assign y_reg_kind = region(y_ea);
  assign x_mis = x_rd_req_in.valid && !x_rd_req_in.is_byte && x_ea[0];
  assign w_mis = wr_req_in.valid && !wr_req_in.is_byte && w_ea[0];
  assign y_act = y_rd_req_in.valid && mac_class_in;

  // SPECIAL_REGISTER_AREA hit comes from peripheral logic of other origin, synchronised
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sfr_hit_s1_reg <= 1'b0;
      sfr_hit_reg <= 1'b0;
    end else begin
      sfr_hit_s1_reg <= sfr_hit_in;
      sfr_hit_reg <= sfr_hit_s1_reg;
    end
  end

  // Read address stage, word aligned X/Y fetch, unaligned byte address to PSV
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      x_rd_addr_out <= DSAU_WORD_ZERO;
      y_rd_addr_out <= DSAU_WORD_ZERO;
      psv_addr_out <= DSAU_WORD_ZERO;
      psv_rd_out <= 1'b0;
      x_kind_reg <= DSAU_REG_NONE;
      y_kind_reg <= DSAU_REG_NONE;
      x_odd_reg <= 1'b0;
      x_byte_reg <= 1'b0;
      y_odd_reg <= 1'b0;
      y_byte_reg <= 1'b0;
      x_ptr_next_out <= DSAU_WORD_ZERO;
      y_ptr_next_out <= DSAU_WORD_ZERO;
    end else begin
      x_rd_addr_out <= {x_ea[15:1], 1'b0};
      y_rd_addr_out <= {y_ea[15:1], 1'b0};
      psv_addr_out <= x_ea;
      psv_rd_out <= x_rd_req_in.valid && !x_mis && x_reg_kind == DSAU_REG_PSV;
      x_kind_reg <= x_mis ? DSAU_REG_NONE : x_reg_kind;
      y_kind_reg <= y_act ? y_reg_kind : DSAU_REG_NONE;
      x_odd_reg <= x_ea[0];
      x_byte_reg <= x_rd_req_in.is_byte;
      y_odd_reg <= y_ea[0];
      y_byte_reg <= y_rd_req_in.is_byte;
      x_ptr_next_out <= next_ptr(x_rd_req_in);
      y_ptr_next_out <= next_ptr(y_rd_req_in);
    end
  end

  // Read data return, zero outside implemented area
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      x_rsp_out <= '0;
      y_rsp_out <= '0;
    end else begin
      x_rsp_out.valid <= x_rd_req_in.valid;
      y_rsp_out.valid <= y_act;
      unique case (x_kind_reg)
        DSAU_REG_RAM: x_rsp_out.data <= lane_pick(x_mem_rdata_in, x_odd_reg, x_byte_reg);
        DSAU_REG_SFR: x_rsp_out.data <= sfr_hit_reg ?
          lane_pick(sfr_rdata_in, x_odd_reg, x_byte_reg) : DSAU_WORD_ZERO;
        DSAU_REG_PSV: x_rsp_out.data <= lane_pick(psv_rdata_in, x_odd_reg, x_byte_reg);
        DSAU_REG_NONE: x_rsp_out.data <= DSAU_WORD_ZERO;
      endcase
      y_rsp_out.data <= (y_kind_reg == DSAU_REG_RAM) ?
        lane_pick(y_mem_rdata_in, y_odd_reg, y_byte_reg) : DSAU_WORD_ZERO;
    end
  end

  // Unified write path; lanes per address, none on misalignment
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      wr_addr_out <= DSAU_WORD_ZERO;
      wr_data_out <= DSAU_WORD_ZERO;
      wr_lane_out <= 2'h0;
      wr_sfr_out <= 1'b0;
      w_ptr_next_out <= DSAU_WORD_ZERO;
    end else begin
      wr_addr_out <= {w_ea[15:1], 1'b0};
      w_ptr_next_out <= next_ptr(wr_req_in);
      wr_sfr_out <= wr_req_in.valid && region(w_ea) == DSAU_REG_SFR;
      if (!wr_req_in.valid || w_mis || region(w_ea) == DSAU_REG_NONE
          || region(w_ea) == DSAU_REG_PSV) begin
        wr_lane_out <= 2'h0;
        wr_data_out <= wr_data_in;
      end else if (wr_req_in.is_byte) begin
        wr_lane_out <= w_ea[0] ? 2'h2 : 2'h1;
        wr_data_out <= {wr_data_in[7:0], wr_data_in[7:0]};
      end else begin
        wr_lane_out <= 2'h3;
        wr_data_out <= wr_data_in;
      end
    end
  end

  // Trap held pending until instruction completes, then one pulse
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      pend_rd_reg <= 1'b0;
      pend_wr_reg <= 1'b0;
      trap_out <= 1'b0;
      trap_is_write_out <= 1'b0;
    end else begin
      trap_out <= 1'b0;
      if (instr_done_in && (pend_rd_reg || pend_wr_reg || x_mis || w_mis)) begin
        trap_out <= 1'b1;
        trap_is_write_out <= pend_wr_reg || w_mis;
        pend_rd_reg <= 1'b0;
        pend_wr_reg <= 1'b0;
      end else begin
        pend_rd_reg <= pend_rd_reg || x_mis;
        pend_wr_reg <= pend_wr_reg || w_mis;
      end
    end
  end

  // Working register byte load and extend ops
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      wreg_result_out <= DSAU_WORD_ZERO;
    end else if (byte_load_in) begin
      wreg_result_out <= {wreg_value_in[15:8], load_byte_in};
    end else begin
      unique case (ext_op_in)
        DSAU_EXT_SIGN: wreg_result_out <= {load_byte_in[7] ? DSAU_BYTE_ONES : DSAU_BYTE_ZERO,
                                           load_byte_in};
        DSAU_EXT_ZERO: wreg_result_out <= {DSAU_BYTE_ZERO, wreg_value_in[7:0]};
        DSAU_EXT_NONE: wreg_result_out <= wreg_value_in;
      endcase
    end
  end

  // Assertions
  property p_lane;
    @(posedge sys_clk_in) disable iff (srst_in)
      (wr_req_in.valid && wr_req_in.is_byte && region(w_ea) == DSAU_REG_RAM)
      |=> (wr_lane_out == ($past(w_ea[0]) ? 2'h2 : 2'h1));
  endproperty
  a_lane: assert property (p_lane) else $error("byte lane wrong");

  property p_suppress;
    @(posedge sys_clk_in) disable iff (srst_in) w_mis |=> wr_lane_out == 2'h0;
  endproperty
  a_suppress: assert property (p_suppress) else $error("misaligned write done");

  property p_trap_pulse;
    @(posedge sys_clk_in) disable iff (srst_in) trap_out |=> !trap_out;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap too long");

  property p_trap_wait;
    @(posedge sys_clk_in) disable iff (srst_in)
      (x_mis && !instr_done_in) |=> !trap_out;
  endproperty
  a_trap_wait: assert property (p_trap_wait) else $error("trap before completion");

  property p_ptr;
    @(posedge sys_clk_in) disable iff (srst_in)
      (x_rd_req_in.post_inc && x_rd_req_in.mode == DSAU_ADR_WREG && x_rd_req_in.is_byte)
      |=> x_ptr_next_out == $past(x_rd_req_in.pointer) + DSAU_STEP_BYTE;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer step wrong");

  property p_zero;
    @(posedge sys_clk_in) disable iff (srst_in)
      (x_rd_req_in.valid && x_reg_kind == DSAU_REG_NONE) |=> ##1 x_rsp_out.data == DSAU_WORD_ZERO;
  endproperty
  a_zero: assert property (p_zero) else $error("unimplemented read not zero");

  property p_psv;
    @(posedge sys_clk_in) disable iff (srst_in)
      (x_rd_req_in.valid && !x_mis && x_ea[DSAU_TOP_BIT]) |=> psv_rd_out;
  endproperty
  a_psv: assert property (p_psv) else $error("psv not routed");

  property p_yonly;
    @(posedge sys_clk_in) disable iff (srst_in) !mac_class_in |=> !y_rsp_out.valid;
  endproperty
  a_yonly: assert property (p_yonly) else $error("Y read without MAC");

  property p_byteload;
    @(posedge sys_clk_in) disable iff (srst_in)
      byte_load_in |=> wreg_result_out[15:8] == $past(wreg_value_in[15:8]);
  endproperty
  a_byteload: assert property (p_byteload) else $error("high byte changed");

  property p_misrd;
    @(posedge sys_clk_in) disable iff (srst_in)
      x_mis |=> ##1 x_rsp_out.data == DSAU_WORD_ZERO;
  endproperty
  a_misrd: assert property (p_misrd) else $error("misaligned read returned data");

  property p_wtrap;
    @(posedge sys_clk_in) disable iff (srst_in)
      (instr_done_in && pend_wr_reg) |=> (trap_out && trap_is_write_out);
  endproperty
  a_wtrap: assert property (p_wtrap) else $error("write trap not flagged");

  property p_wpsv;
    @(posedge sys_clk_in) disable iff (srst_in)
      (wr_req_in.valid && w_ea[DSAU_TOP_BIT]) |=> wr_lane_out == 2'h0;
  endproperty
  a_wpsv: assert property (p_wpsv) else $error("write reached upper half");

  property p_sext;
    @(posedge sys_clk_in) disable iff (srst_in)
      (!byte_load_in && ext_op_in == DSAU_EXT_SIGN)
      |=> wreg_result_out[15:8] == ($past(load_byte_in[7]) ? DSAU_BYTE_ONES : DSAU_BYTE_ZERO);
  endproperty
  a_sext: assert property (p_sext) else $error("sign extend wrong");

  property p_wstep;
    @(posedge sys_clk_in) disable iff (srst_in)
      (wr_req_in.post_inc && wr_req_in.mode == DSAU_ADR_WREG && !wr_req_in.is_byte)
      |=> w_ptr_next_out == $past(wr_req_in.pointer) + DSAU_STEP_WORD;
  endproperty
  a_wstep: assert property (p_wstep) else $error("word pointer step wrong");

endmodule // dsau_unit

// File: dsau_pkg.sv
// Package for the data-space address unit: map constants and carrier types
package dsau_pkg;
  localparam int DSAU_AW = 16;
  localparam int DSAU_DW = 16;
  localparam logic [15:0] DSAU_SFR_LAST = 16'h0FFF;
  localparam logic [15:0] DSAU_NEAR_LAST = 16'h1FFF;
  localparam logic [15:0] DSAU_RAM_FIRST = 16'h1000;
  localparam logic [15:0] DSAU_RAM_END = 16'h4000;  // 16 Kbyte implemented limit
  localparam logic [15:0] DSAU_XY_BOUNDARY = 16'h3000;
  localparam int DSAU_TOP_BIT = 15;
  localparam int DSAU_NEAR_BITS = 13;
  localparam logic [15:0] DSAU_STEP_BYTE = 16'h0001;
  localparam logic [15:0] DSAU_STEP_WORD = 16'h0002;
  localparam logic [7:0] DSAU_BYTE_ZERO = 8'h00;
  localparam logic [7:0] DSAU_BYTE_ONES = 8'hFF;
  localparam logic [15:0] DSAU_WORD_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    DSAU_ADR_WREG,    // indirect through working register pointer
    DSAU_ADR_NEAR,    // 13-bit absolute field
    DSAU_ADR_DIRECT   // 16-bit absolute field
  } dsau_mode_type;

  typedef enum logic [1:0] {
    DSAU_EXT_NONE,
    DSAU_EXT_SIGN,
    DSAU_EXT_ZERO
  } dsau_ext_type;

  typedef enum logic [1:0] {
    DSAU_REG_NONE,
    DSAU_REG_SFR,
    DSAU_REG_RAM,
    DSAU_REG_PSV
  } dsau_region_type;

  // One address generator request
  typedef struct packed {
    logic valid;
    logic is_byte;
    logic post_inc;
    dsau_mode_type mode;
    logic [15:0] pointer;
    logic [15:0] literal;
  } dsau_req_type;

  // Response of one read path
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } dsau_rsp_type;
endpackage

// File: dsau_mem_model.sv
// Word memory and register-area model facing the data-space address unit
`timescale 1ns/100ps
module dsau_mem_model
  import dsau_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [15:0] x_addr_in,
  input wire logic [15:0] y_addr_in,
  input wire logic [15:0] psv_addr_in,
  input wire logic [15:0] wr_addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [1:0] wr_lane_in,
  output logic [15:0] x_data_out,
  output logic [15:0] y_data_out,
  output logic [15:0] sfr_data_out,
  output logic [15:0] psv_data_out
);
  logic [15:0] ram_reg [0:8191];
  // Fill: high byte is the low byte of the word index, low byte its inverse
  initial begin
    for (int i = 0; i < 8192; i++) begin
      ram_reg[i] = {i[7:0], ~i[7:0]};
    end
  end
  // Each lane writes only its own byte of the word
  always @(posedge sys_clk_in) begin
    if (wr_lane_in[0]) begin
      ram_reg[wr_addr_in[13:1]][7:0] <= wr_data_in[7:0];
    end
    if (wr_lane_in[1]) begin
      ram_reg[wr_addr_in[13:1]][15:8] <= wr_data_in[15:8];
    end
  end
  // Data follows the address; no zeroing outside RAM, so the unit must do it
  assign x_data_out = ram_reg[x_addr_in[13:1]];
  assign y_data_out = ram_reg[y_addr_in[13:1]];
  assign sfr_data_out = {~x_addr_in[7:0], x_addr_in[7:0]};
  assign psv_data_out = ~psv_addr_in;
endmodule // dsau_mem_model

// File: test_data_space_address_unit.sv
// Self-checking testbench for the data-space address unit
`timescale 1ns/100ps
module test_data_space_address_unit
  import dsau_pkg::*;
;
  logic sys_clk, srst, mac, done, hit, bl, prd, wsfr, trap, trw;
  logic [15:0] wd, wv, xa, ya, pa, wa, wdo, xp, yp, wp, wres, xm, ym, sd, pd;
  logic [7:0] lb;
  logic [1:0] lane;
  dsau_ext_type ext;
  dsau_req_type xr, yr, wr;
  dsau_rsp_type xs, ys;
  int fail_count, num_checks;
  int cycles = 0;

  dsau_unit dsau_unit_i (.sys_clk_in(sys_clk), .srst_in(srst), .x_rd_req_in(xr),
    .y_rd_req_in(yr), .mac_class_in(mac), .wr_req_in(wr), .wr_data_in(wd),
    .instr_done_in(done), .x_mem_rdata_in(xm), .y_mem_rdata_in(ym), .sfr_rdata_in(sd),
    .sfr_hit_in(hit), .psv_rdata_in(pd), .wreg_value_in(wv), .load_byte_in(lb),
    .byte_load_in(bl), .ext_op_in(ext), .x_rd_addr_out(xa), .y_rd_addr_out(ya),
    .psv_addr_out(pa), .psv_rd_out(prd), .wr_addr_out(wa), .wr_data_out(wdo),
    .wr_lane_out(lane), .wr_sfr_out(wsfr), .x_rsp_out(xs), .y_rsp_out(ys),
    .x_ptr_next_out(xp), .y_ptr_next_out(yp), .w_ptr_next_out(wp),
    .wreg_result_out(wres), .trap_out(trap), .trap_is_write_out(trw));
  dsau_mem_model dsau_mem_model_i (.sys_clk_in(sys_clk), .x_addr_in(xa), .y_addr_in(ya),
    .psv_addr_in(pa), .wr_addr_in(wa), .wr_data_in(wdo), .wr_lane_in(lane),
    .x_data_out(xm), .y_data_out(ym), .sfr_data_out(sd), .psv_data_out(pd));

  // Clock at 40 ns period
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic dsau_req_type mk(input logic [15:0] p, input logic b, input dsau_mode_type m);
    mk = '{1'b1, b, m == DSAU_ADR_WREG, m, p, p};
  endfunction

  // One X read: address and pointer a cycle after, data a cycle later
  task automatic rd(input dsau_req_type r, input logic [15:0] ea, ep, ed);
    @(negedge sys_clk);
    xr = r;
    @(negedge sys_clk);
    xr = '0;
    chk(xa, ea);
    chk(16'(xs.valid), 16'h0001);
    if (r.mode == DSAU_ADR_WREG) chk(xp, ep);
    @(negedge sys_clk);
    chk(xs.data, ed);
  endtask

  // One write: lanes, aligned address, replicated data, pointer step
  task automatic wrt(input dsau_req_type r, input logic [15:0] d, input logic [1:0] el,
                     input logic [15:0] ea, ed);
    @(negedge sys_clk);
    wr = r;
    wd = d;
    @(negedge sys_clk);
    wr = '0;
    chk(16'(lane), 16'(el));
    chk(wp, r.pointer + (r.is_byte ? 16'h0001 : 16'h0002));
    chk(16'(wsfr), 16'(r.pointer <= DSAU_SFR_LAST));
    if (el != 2'b00) begin
      chk(wa, ea);
      chk(wdo, ed);
    end
  endtask

  // Trap waits for instruction end, then pulses once
  task automatic trap_seq(input logic w);
    chk(16'(trap), 16'h0000);
    @(negedge sys_clk);
    done = 1'b1;
    @(negedge sys_clk);
    done = 1'b0;
    chk(16'(trap), 16'h0001);
    chk(16'(trw), 16'(w));
    @(negedge sys_clk);
    chk(16'(trap), 16'h0000);
  endtask

  task automatic t_read();
    rd(mk(16'h1000, 1'b0, DSAU_ADR_WREG), 16'h1000, 16'h1002, 16'h00FF);
    rd(mk(16'h1003, 1'b1, DSAU_ADR_WREG), 16'h1002, 16'h1004, 16'h0001);
    rd(mk(16'h1002, 1'b1, DSAU_ADR_WREG), 16'h1002, 16'h1003, 16'h00FE);
  endtask

  task automatic t_space();
    rd(mk(16'h5000, 1'b0, DSAU_ADR_WREG), 16'h5000, 16'h5002, 16'h0000);
    rd(mk(16'h0040, 1'b0, DSAU_ADR_WREG), 16'h0040, 16'h0042, 16'h0000);
    hit = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(mk(16'h0040, 1'b0, DSAU_ADR_WREG), 16'h0040, 16'h0042, 16'hBF40);
    hit = 1'b0;
    rd(mk(16'hFFFE, 1'b0, DSAU_ADR_NEAR), 16'h1FFE, 16'h0000, 16'hFF00);
    rd(mk(16'h2468, 1'b0, DSAU_ADR_DIRECT), 16'h2468, 16'h0000, 16'h34CB);
    @(negedge sys_clk);
    xr = mk(16'h8004, 1'b0, DSAU_ADR_WREG);
    @(negedge sys_clk);
    xr = '0;
    chk(16'(prd), 16'h0001);
    chk(pa, 16'h8004);
    @(negedge sys_clk);
    chk(16'(prd), 16'h0000);
    chk(xs.data, 16'h7FFB);
  endtask

  task automatic t_write();
    wrt(mk(16'h1005, 1'b1, DSAU_ADR_WREG), 16'h77AB, 2'b10, 16'h1004, 16'hABAB);
    rd(mk(16'h1004, 1'b0, DSAU_ADR_WREG), 16'h1004, 16'h1006, 16'hABFD);
    wrt(mk(16'h1008, 1'b1, DSAU_ADR_WREG), 16'h0055, 2'b01, 16'h1008, 16'h5555);
    rd(mk(16'h1008, 1'b0, DSAU_ADR_WREG), 16'h1008, 16'h100A, 16'h0455);
    wrt(mk(16'h3000, 1'b0, DSAU_ADR_WREG), 16'hBEEF, 2'b11, 16'h3000, 16'hBEEF);
    wrt(mk(16'h8000, 1'b0, DSAU_ADR_WREG), 16'h1111, 2'b00, 16'h0000, 16'h0000);
    wrt(mk(16'h0100, 1'b0, DSAU_ADR_WREG), 16'h1234, 2'b11, 16'h0100, 16'h1234);
  endtask

  task automatic t_trap();
    rd(mk(16'h1201, 1'b0, DSAU_ADR_WREG), 16'h1200, 16'h1203, 16'h0000);
    trap_seq(1'b0);
    wrt(mk(16'h1207, 1'b0, DSAU_ADR_WREG), 16'hDEAD, 2'b00, 16'h0000, 16'h0000);
    trap_seq(1'b1);
    rd(mk(16'h1206, 1'b0, DSAU_ADR_WREG), 16'h1206, 16'h1208, 16'h03FC);
  endtask

  // Concurrent X and Y fetch; Y answers only for the multiply class
  task automatic dual(input logic m);
    @(negedge sys_clk);
    xr = mk(16'h1010, 1'b0, DSAU_ADR_WREG);
    yr = mk(16'h3000, 1'b0, DSAU_ADR_WREG);
    mac = m;
    @(negedge sys_clk);
    xr = '0;
    yr = '0;
    chk(16'(ys.valid), 16'(m));
    if (m) chk(ya, 16'h3000);
    if (m) chk(yp, 16'h3002);
    @(negedge sys_clk);
    mac = 1'b0;
    chk(xs.data, 16'h08F7);
    if (m) chk(ys.data, 16'hBEEF);
  endtask

  task automatic t_ext();
    wv = 16'h1234;
    lb = 8'h9C;
    @(negedge sys_clk);
    bl = 1'b1;
    @(negedge sys_clk);
    bl = 1'b0;
    ext = DSAU_EXT_SIGN;
    chk(wres, 16'h129C);
    @(negedge sys_clk);
    ext = DSAU_EXT_ZERO;
    chk(wres, 16'hFF9C);
    @(negedge sys_clk);
    ext = DSAU_EXT_NONE;
    chk(wres, 16'h0034);
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    xr = '0;
    yr = '0;
    wr = '0;
    {mac, done, hit, bl} = 4'h0;
    wd = 16'h0000;
    wv = 16'h0000;
    lb = 8'h00;
    ext = DSAU_EXT_NONE;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(negedge sys_clk);
    chk(16'(trap), 16'h0000);
    chk(16'(xs.valid), 16'h0000);
    srst = 1'b0;
    t_read();
    t_space();
    t_write();
    t_trap();
    dual(1'b1);
    dual(1'b0);
    t_ext();
    complete_run();
  end
endmodule // test_data_space_address_unit
